// File: include/pset_pkg.sv
package pset_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and counts of lanes
  localparam int NUM_PPS   = 8;
  localparam int NUM_TRIG  = 8;
  localparam int SEL_W     = 3;
  localparam int CNT_W     = 27;
  localparam int SUB_W     = 16;
  localparam int SEC_W     = 32;
  localparam int SAMPLE_W  = 24;
  localparam int THR_W     = 16;
  localparam int PULSE_W   = 15;
  localparam int FILT_W    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, in nanoseconds and in cycles of mclk
  localparam int CLK_PERIOD_NS   = 40;
  localparam int FILT_TIME_NS    = 1000;
  localparam int FILT_CYCLES     =
    (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES     = 2;
  localparam int FILT_DELAY_CYCLES = SYNC_STAGES + FILT_CYCLES + 1;
  localparam int WIN_UNIT_NS     = 10240;
  localparam int WIN_UNIT_CYCLES = WIN_UNIT_NS / CLK_PERIOD_NS;
  localparam int OUT_PULSE_NS    = 1000000;
  localparam int OUT_PULSE_CYCLES = OUT_PULSE_NS / CLK_PERIOD_NS;
  localparam int SECOND_NS       = 1000000000;
  localparam int NOMINAL_CYCLES  = SECOND_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Subsecond scaling and reset values
  localparam logic [CNT_W:0]   SUB_STEP  = 28'h0010000;
  localparam logic [CNT_W-1:0] ACC_ALIGN =
    CNT_W'(FILT_DELAY_CYCLES * 65536);
  localparam logic [SUB_W-1:0] SUB_MAX   = 16'hFFFF;
  localparam logic [SUB_W-1:0] SUB_RST   = 16'h0000;
  localparam logic [SEC_W-1:0] SEC_RST   = 32'h00000000;
  localparam logic             SRC_EXTERNAL = 1'b0;
  localparam logic             SRC_INTERNAL = 1'b1;

  // Lock sequence states
  typedef enum logic [3:0] {
    ST_INT   = 4'b0001,
    ST_WAIT1 = 4'b0010,
    ST_WAIT2 = 4'b0100,
    ST_LOCK  = 4'b1000
  } pset_lock_t;

  // Packs the low seconds and the subseconds into one sample
  function automatic logic [SAMPLE_W-1:0] pset_sample(
    input logic [SEC_W-1:0] sec,
    input logic [SUB_W-1:0] sub
  );
    pset_sample = {sec[7:0], sub};
  endfunction : pset_sample

endpackage : pset_pkg

// File: include/pset_strobe_if.sv
`timescale 1ns/1ps
// Selected pulse level in, qualification strobe out
interface pset_strobe_if;
  logic level;
  logic strobe;
  modport filt (input level, output strobe);
  modport ctrl (output level, input strobe);
endinterface : pset_strobe_if

// File: verilog/pset_input_filter.sv
`timescale 1ns/1ps
module pset_input_filter (
  input  wire logic      mclk,  // System clock
  input  wire logic      reset, // Async reset, active high
  input  wire logic      clkEn, // Freezes state while low
  pset_strobe_if.filt    pps    // Level in, strobe out
);
  import pset_pkg::*;

  logic [FILT_W-1:0] highCnt_q;
  logic              strobe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count consecutive high samples, saturating
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      highCnt_q <= '0;
    end else if (clkEn) begin
      if (!pps.level) begin
        highCnt_q <= '0;
      end else if (highCnt_q != FILT_W'(FILT_CYCLES)) begin
        highCnt_q <= highCnt_q + 5'h1;
      end
    end
  end

  // One strobe per pulse, once it has lasted long enough
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strobe_q <= 1'b0;
    end else if (clkEn) begin
      strobe_q <= pps.level &&
                  (highCnt_q == FILT_W'(FILT_CYCLES - 1));
    end
  end

  assign pps.strobe = strobe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  property p_filt_width;
    (strobe_q && $past(clkEn)) |-> $past(pps.level, 1) && $past(pps.level, 8);
  endproperty
  a_filt_width: assert property (p_filt_width)
    else $error("strobe without a long enough pulse");

  property p_filt_single;
    (strobe_q && clkEn) |=> !strobe_q;
  endproperty
  a_filt_single: assert property (p_filt_single)
    else $error("strobe longer than one cycle");

endmodule : pset_input_filter

// File: verilog/pset_elapsed_timer.sv
`timescale 1ns/1ps
// Overview of operation
// - Select input picks exactly one pulse input as the sync reference.
// - Filter passes only pulses of at least 1 us, one strobe each.
// - Interval between accepted pulses is measured continuously.
// - Outputs pulse 1 ms long, only on enabled outputs.
// - Time is seconds plus subseconds of 1/65536 second.
// - Internal mode counts from power on, never aligned to external pulses.
// - External mode syncs second boundaries to pulses inside the window.
// - Early pulse or expiry while locked reverts to internal, same interval.
// - Subsecond length scales so every second holds 65536 subseconds.
// - Qualified, unqualified and expired events arise in every mode.
// - Window is plus or minus (1+N) times 10.24 us.
// - Next window is placed from the last pulse, qualified or not.
// - After expiry the next window is placed from the expired midpoint.
// - Each window elapsing without a pulse raises an expired event.
// - First qualified pulse syncs time silently; next one aligns outputs.
// - Alignment happens on the first two qualified pulses per entry into external mode.
// - Alignment compensates the delay added by the input filter.
// - A fired trigger captures 24 bits of time at any moment.
// - Samples hold low 8 seconds bits over 16 subsecond bits.
// - Trigger polarity 0 rising, 1 falling; triggers default disabled.
// - Source select 0 external, 1 internal; resets to internal.
// - Eight enable bits gate each output driver; reset all disabled.
module pset_elapsed_timer #(
  parameter logic [pset_pkg::CNT_W-1:0]   NOMINAL_INTERVAL =
    pset_pkg::CNT_W'(pset_pkg::NOMINAL_CYCLES),   // Cycles per second
  parameter logic [pset_pkg::PULSE_W-1:0] OUT_PULSE_LEN    =
    pset_pkg::PULSE_W'(pset_pkg::OUT_PULSE_CYCLES) // Output pulse cycles
) (
  input  wire logic                          mclk,           // Clock
  input  wire logic                          reset,          // Async reset
  input  wire logic                          clkEn,          // Clock enable
  input  wire logic [pset_pkg::NUM_PPS-1:0]  ppsIn,          // Pulse pins
  input  wire logic [pset_pkg::SEL_W-1:0]    ppsInputSelect, // Input pick
  input  wire logic                          timingSource,   // 0 ext 1 int
  input  wire logic [pset_pkg::THR_W-1:0]    ppsThreshold,   // Window N
  input  wire logic [pset_pkg::NUM_PPS-1:0]  ppsOutEnable,   // Drivers on
  input  wire logic [pset_pkg::NUM_TRIG-1:0] eventCaptureTrigger, // Pins
  input  wire logic [pset_pkg::NUM_TRIG-1:0] trigPolarity,   // 1 falling
  input  wire logic [pset_pkg::NUM_TRIG-1:0] trigEnable,     // Trig on
  output logic      [pset_pkg::NUM_PPS-1:0]  ppsOut,         // Pulse out
  output logic      [pset_pkg::SEC_W-1:0]    secondsCount,   // Seconds
  output logic      [pset_pkg::SUB_W-1:0]    subsecondsCount,// Subseconds
  output logic      [pset_pkg::SAMPLE_W-1:0] arrivalSample,  // At pulse
  output logic      [pset_pkg::NUM_TRIG-1:0][pset_pkg::SAMPLE_W-1:0]
                                             captureSample,  // At triggers
  output logic                               qualifiedEvent, // Pulse
  output logic                               unqualifiedEvent, // Pulse
  output logic                               expiredEvent,   // Pulse
  output logic                               lockLost,       // Pulse
  output logic                               externalLocked, // Level
  output logic                               sourceInternal  // Level
);
  import pset_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [NUM_PPS-1:0]  ppsSync1_q, ppsSync2_q;
  logic [NUM_TRIG-1:0] trigSync1_q, trigSync2_q, trigPrev_q, trigFire;
  logic [CNT_W-1:0]    sinceRef_q, sincePulse_q, measured_q;
  logic [CNT_W-1:0]    curInterval_q, acc_q, halfWin, earlyLimit;
  logic [CNT_W:0]      lateLimit, accNext;
  logic [SUB_W-1:0]    subsec_q, alignSub;
  logic [SEC_W-1:0]    seconds_q;
  logic [PULSE_W-1:0]  pulseCnt_q;
  logic                ppsActive_q, reqPrev_q, extReq;
  logic                strobe, early, qualify, expire;
  logic                subTick, secWrap, align, ppsStart, loss;
  pset_lock_t          lockState_q, lockState_d;

  pset_strobe_if ppsLink ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ppsSync1_q  <= '0;
      ppsSync2_q  <= '0;
      trigSync1_q <= '0;
      trigSync2_q <= '0;
      trigPrev_q  <= '0;
    end else if (clkEn) begin
      ppsSync1_q  <= ppsIn;
      ppsSync2_q  <= ppsSync1_q;
      trigSync1_q <= eventCaptureTrigger;
      trigSync2_q <= trigSync1_q;
      trigPrev_q  <= trigSync2_q;
    end
  end

  // Input mux and length filter
  assign ppsLink.level = ppsSync2_q[ppsInputSelect];
  assign strobe        = ppsLink.strobe;

  pset_input_filter u_filter (
    .mclk  (mclk),
    .reset (reset),
    .clkEn (clkEn),
    .pps   (ppsLink.filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Window classification
  assign halfWin    = CNT_W'(({11'h000, ppsThreshold} + 27'h1) *
                             CNT_W'(WIN_UNIT_CYCLES));
  assign lateLimit  = {1'b0, measured_q} + {1'b0, halfWin};
  assign earlyLimit = (measured_q > halfWin) ? measured_q - halfWin : '0;
  assign early      = strobe && (sinceRef_q < earlyLimit);
  assign qualify    = strobe && !early;
  assign expire     = !strobe && ({1'b0, sinceRef_q} >= lateLimit);

  // Distance from the window reference point
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sinceRef_q <= '0;
    end else if (clkEn) begin
      if (strobe) begin
        sinceRef_q <= CNT_W'(FILT_DELAY_CYCLES);
      end else if (expire) begin
        sinceRef_q <= sinceRef_q - measured_q;
      end else if (sinceRef_q != '1) begin
        sinceRef_q <= sinceRef_q + 27'h1;
      end
    end
  end

  // Interval between accepted pulses
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sincePulse_q <= '0;
      measured_q   <= NOMINAL_INTERVAL;
    end else if (clkEn) begin
      if (strobe) begin
        sincePulse_q <= 27'h1;
      end else if (sincePulse_q != '1) begin
        sincePulse_q <= sincePulse_q + 27'h1;
      end
      if (qualify) begin
        measured_q <= sincePulse_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock sequence
  assign extReq = (timingSource == SRC_EXTERNAL);
  assign loss   = early || expire;

  always_comb begin
    lockState_d = lockState_q;
    unique case (lockState_q)
      ST_INT: begin
        if (extReq && reqPrev_q == SRC_INTERNAL) begin
          lockState_d = ST_WAIT1;
        end
      end
      ST_WAIT1: begin
        if (!extReq || loss) begin
          lockState_d = ST_INT;
        end else if (qualify) begin
          lockState_d = ST_WAIT2;
        end
      end
      ST_WAIT2: begin
        if (!extReq || loss) begin
          lockState_d = ST_INT;
        end else if (qualify) begin
          lockState_d = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (!extReq || loss) begin
          lockState_d = ST_INT;
        end
      end
      default: lockState_d = ST_INT;
    endcase
  end

  // State and request history
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lockState_q <= ST_INT;
      reqPrev_q   <= SRC_INTERNAL;
    end else if (clkEn) begin
      lockState_q <= lockState_d;
      reqPrev_q   <= timingSource;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scaled subsecond engine
  assign accNext = {1'b0, acc_q} + SUB_STEP;
  assign subTick = accNext >= {1'b0, curInterval_q};
  assign align   = qualify &&
                   (lockState_q == ST_WAIT1 || lockState_q == ST_WAIT2);
  assign secWrap = subTick && (subsec_q == SUB_MAX) && !align;
  // At one subsecond per cycle a preload cannot drain, so load the count
  assign alignSub = ({1'b0, measured_q} <= SUB_STEP) ?
                    SUB_W'(FILT_DELAY_CYCLES) : SUB_RST;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc_q         <= '0;
      subsec_q      <= SUB_RST;
      seconds_q     <= SEC_RST;
      curInterval_q <= NOMINAL_INTERVAL;
    end else if (clkEn) begin
      if (align) begin
        acc_q         <= (alignSub == SUB_RST) ? ACC_ALIGN : '0;
        subsec_q      <= alignSub;
        seconds_q     <= seconds_q + {31'h0, subsec_q[SUB_W-1]};
        curInterval_q <= measured_q;
      end else begin
        acc_q <= subTick ? CNT_W'(accNext - {1'b0, curInterval_q})
                         : CNT_W'(accNext);
        if (subTick) begin
          subsec_q <= subsec_q + 16'h1;
        end
        if (secWrap) begin
          seconds_q     <= seconds_q + 32'h1;
          curInterval_q <= measured_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pulse generator
  // A pulse already started at an aligned wrap is not stretched
  assign ppsStart = secWrap ||
                    (align && lockState_q == ST_WAIT2 && !ppsActive_q);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ppsActive_q <= 1'b0;
      pulseCnt_q  <= '0;
      ppsOut      <= '0;
    end else if (clkEn) begin
      if (ppsStart) begin
        ppsActive_q <= 1'b1;
        pulseCnt_q  <= '0;
      end else if (ppsActive_q) begin
        if (pulseCnt_q == OUT_PULSE_LEN - 15'h1) begin
          ppsActive_q <= 1'b0;
        end else begin
          pulseCnt_q <= pulseCnt_q + 15'h1;
        end
      end
      ppsOut <= ppsActive_q ? ppsOutEnable : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time samples and event outputs
  assign trigFire = trigEnable & (trigPrev_q ^ trigSync2_q) &
                    (trigPolarity ^ trigSync2_q);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arrivalSample <= '0;
      captureSample <= '0;
    end else if (clkEn) begin
      if (strobe) begin
        arrivalSample <= pset_sample(seconds_q, subsec_q);
      end
      for (int k = 0; k < NUM_TRIG; k++) begin
        if (trigFire[k]) begin
          captureSample[k] <= pset_sample(seconds_q, subsec_q);
        end
      end
    end
  end

  // Registered status and event pulses
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      qualifiedEvent   <= 1'b0;
      unqualifiedEvent <= 1'b0;
      expiredEvent     <= 1'b0;
      lockLost         <= 1'b0;
      externalLocked   <= 1'b0;
      sourceInternal   <= 1'b1;
    end else if (clkEn) begin
      qualifiedEvent   <= qualify;
      unqualifiedEvent <= early;
      expiredEvent     <= expire;
      lockLost         <= loss && extReq && lockState_q != ST_INT;
      externalLocked   <= lockState_d == ST_LOCK;
      sourceInternal   <= lockState_d == ST_INT;
    end
  end

  assign secondsCount    = seconds_q;
  assign subsecondsCount = subsec_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  property p_src_internal;
    (timingSource && clkEn) |=> lockState_q == ST_INT;
  endproperty
  a_src_internal: assert property (p_src_internal)
    else $error("internal source selected but not in internal state");

  property p_sec_wrap;
    (secWrap && clkEn) |=> seconds_q == $past(seconds_q) + 32'h1
                          && subsec_q == 16'h0;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap)
    else $error("subsecond wrap did not advance seconds");

  property p_pulse_len;
    $fell(ppsActive_q) |-> $past(pulseCnt_q) == OUT_PULSE_LEN - 15'h1;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("output pulse has wrong length");

  property p_out_gate;
    $past(clkEn) |-> (ppsOut & ~$past(ppsOutEnable)) == '0;
  endproperty
  a_out_gate: assert property (p_out_gate)
    else $error("disabled output driven");

  property p_lock_loss;
    (lockState_q == ST_LOCK && loss && clkEn) |=> lockState_q == ST_INT
                                                 ##0 lockLost;
  endproperty
  a_lock_loss: assert property (p_lock_loss)
    else $error("lock not dropped on early or expired pulse");

  property p_expire_move;
    (expire && clkEn) |=> expiredEvent &&
      sinceRef_q == $past(sinceRef_q) - $past(measured_q);
  endproperty
  a_expire_move: assert property (p_expire_move)
    else $error("expiry not flagged or window not moved");

  property p_first_silent;
    (lockState_q == ST_WAIT1 && qualify && clkEn) |=>
      subsec_q == $past(alignSub) ##1 !$rose(ppsActive_q);
  endproperty
  a_first_silent: assert property (p_first_silent)
    else $error("first sync pulse produced an output");

  property p_trig_capture;
    (trigFire[0] && clkEn) |=>
      captureSample[0] == {$past(seconds_q[7:0]), $past(subsec_q)};
  endproperty
  a_trig_capture: assert property (p_trig_capture)
    else $error("trigger sample not captured");

  property p_qual_window;
    qualifiedEvent |-> $past(sinceRef_q) >= $past(earlyLimit);
  endproperty
  a_qual_window: assert property (p_qual_window)
    else $error("pulse qualified ahead of window");

  c_locked:  cover property (lockState_q == ST_LOCK);
  c_expired: cover property (expiredEvent);
  c_unqual:  cover property (unqualifiedEvent);
  c_trigger: cover property (trigFire != '0);

endmodule : pset_elapsed_timer

// File: tb/pset_pps_source.sv
`timescale 1ns/1ps
module pset_pps_source (
  input  wire logic mclk, // System clock
  output logic      pin   // Pulse line, idle low
);
  int   cnt     = 0;
  int   per     = 0;
  int   wid     = 0;
  int   oneLeft = 0;
  logic run     = 1'b0;

  initial pin = 1'b0;

  //////////////////////////////////////////////////
  // Periodic train, or a single pulse while stopped
  always @(posedge mclk) begin
    if (run) begin
      cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
      pin <= (cnt < wid);
    end else begin
      pin <= (oneLeft > 0);
      if (oneLeft > 0) oneLeft <= oneLeft - 1;
    end
  end

  // Controls used by the bench
  task start(input int w, input int p);
    wid <= w;
    per <= p;
    cnt <= 0;
    run <= 1'b1;
  endtask : start

  task one(input int w);
    oneLeft <= w;
  endtask : one

  task nudge(input int d);
    cnt <= cnt + d;
  endtask : nudge

  task stop();
    run <= 1'b0;
  endtask : stop
endmodule : pset_pps_source

// File: tb/pset_tb.sv
`timescale 1ns/1ps
module tb;
  import pset_pkg::*;
  localparam int P     = 65536;
  localparam int OPL   = 50;
  localparam int LIMIT = 600000;

  logic                              mclk  = 1'b0;
  logic                              reset = 1'b1;
  logic                              spare = 1'b0;
  logic                              en    = 1'b1;
  logic [NUM_PPS-1:0]                outEn = 8'hA5;
  logic                              src   = 1'b1;
  logic [NUM_TRIG-1:0]               trig  = 8'h00;
  logic [NUM_TRIG-1:0]               tPol  = 8'h00;
  logic [NUM_TRIG-1:0]               tEn   = 8'h00;
  logic [NUM_PPS-1:0]                prevOut = 8'h00;
  logic                              srcPin;
  logic [NUM_PPS-1:0]                ppsOut;
  logic [SEC_W-1:0]                  sec;
  logic [SUB_W-1:0]                  sub;
  logic [SAMPLE_W-1:0]               arr;
  logic [NUM_TRIG-1:0][SAMPLE_W-1:0] cap;
  logic                              qEv, uEv, xEv, lost, locked, intl;
  int                                cycles = 0;
  int                                miscompares = 0;
  int                                testsRun = 0;
  int                                rises = 0;

  // Block under test and the far-side pulse source
  pset_elapsed_timer #(
    .NOMINAL_INTERVAL(27'(P)),
    .OUT_PULSE_LEN   (15'(OPL))
  ) dut (
    .mclk(mclk), .reset(reset), .clkEn(en),
    .ppsIn({2'b00, spare, 1'b0, srcPin, 3'b000}),
    .ppsInputSelect(3'h3), .timingSource(src), .ppsThreshold(16'h0000),
    .ppsOutEnable(outEn), .eventCaptureTrigger(trig),
    .trigPolarity(tPol), .trigEnable(tEn), .ppsOut(ppsOut),
    .secondsCount(sec), .subsecondsCount(sub), .arrivalSample(arr),
    .captureSample(cap), .qualifiedEvent(qEv), .unqualifiedEvent(uEv),
    .expiredEvent(xEv), .lockLost(lost), .externalLocked(locked),
    .sourceInternal(intl)
  );
  pset_pps_source ppsSrc (.mclk(mclk), .pin(srcPin));

  //////////////////////////////////////////////////
  // Clock, hang guard and output pulse counter
  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      print_verdict();
    end
  end

  always @(negedge mclk) begin
    if (ppsOut !== 8'h00 && prevOut === 8'h00) rises++;
    prevOut = ppsOut;
  end

  // Shared helpers
  task automatic chk(input string nm, input logic [31:0] e, g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  function automatic logic near(input logic [15:0] a, b);
    return 16'(a - b) <= 16'd5;
  endfunction : near

  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick

  task automatic waitEv(input int lim, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (qEv !== 1'b1 && uEv !== 1'b1 && xEv !== 1'b1 && n < lim);
  endtask : waitEv

  task automatic print_verdict;
    if (miscompares == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  //////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk("seconds", 0, sec);
    chk("subseconds", 0, sub);
    chk("sourceInternal", 1, intl);
    chk("ppsOut", 0, ppsOut);
    chk("capture0", 0, cap[0]);
    chk("locked", 0, locked);
  endtask : t_reset

  task automatic t_count;
    logic [SUB_W-1:0] s;
    tick(1);
    s = sub + 16'd100;
    tick(100);
    chk("subAdvance", s, sub);
  endtask : t_count

  // Clock enable low freezes the count, which resumes afterwards
  task automatic t_freeze;
    logic [SUB_W-1:0] s;
    @(posedge mclk);
    en <= 1'b0;
    tick(1);
    s = sub;
    tick(10);
    chk("frozen", s, sub);
    @(posedge mclk);
    en <= 1'b1;
    tick(4);
    chk("thawed", s + 16'd3, sub);
  endtask : t_freeze

  task automatic t_trig;
    logic [SUB_W-1:0]    s;
    logic [SAMPLE_W-1:0] c0;
    @(posedge mclk);
    tEn <= 8'h03;
    tPol <= 8'h02;
    tick(4);
    @(posedge mclk);
    trig <= 8'h07;
    tick(1);
    s = sub;
    tick(8);
    chk("cap0Sub", 1, near(cap[0][15:0], s));
    chk("cap0Sec", sec[7:0], cap[0][23:16]);
    chk("cap1Rise", 0, cap[1]);
    chk("cap2Off", 0, cap[2]);
    c0 = cap[0];
    @(posedge mclk);
    trig <= 8'h00;
    tick(1);
    s = sub;
    tick(8);
    chk("cap1Sub", 1, near(cap[1][15:0], s));
    chk("cap0Fall", c0, cap[0]);
  endtask : t_trig

  task automatic t_filter;
    int n;
    ppsSrc.one(20);
    waitEv(60, n);
    chk("shortPulse", 0, qEv | uEv);
    @(posedge mclk);
    spare <= 1'b1;
    waitEv(60, n);
    chk("otherInput", 0, qEv | uEv);
    @(posedge mclk);
    spare <= 1'b0;
    n = 0;
    while (sub !== 16'h0400 && n < P) begin
      tick(1);
      n++;
    end
    ppsSrc.start(30, P);
    waitEv(60, n);
    chk("longPulse", 1, qEv | uEv);
    chk("arrivalSec", sec[7:0], arr[23:16]);
  endtask : t_filter

  task automatic t_wrap;
    logic [SEC_W-1:0] s;
    int               n;
    n = 0;
    while (sub !== SUB_MAX && n < P) begin
      tick(1);
      n++;
    end
    s = sec + 32'd1;
    tick(1);
    chk("subWrap", 0, sub);
    chk("secWrap", s, sec);
    n = 0;
    while (ppsOut === 8'h00 && n < 10) begin
      tick(1);
      n++;
    end
    chk("ppsOutEn", 8'hA5, ppsOut);
    n = 0;
    while (ppsOut === 8'hA5 && n < 2 * OPL) begin
      tick(1);
      n++;
    end
    chk("ppsOutLen", OPL, n);
  endtask : t_wrap

  task automatic t_window;
    int n;
    waitEv(P + 300, n);
    chk("qualOnTime", 1, qEv);
    ppsSrc.nudge(600);
    waitEv(P, n);
    chk("earlyUnqual", 1, uEv);
    waitEv(P + 300, n);
    chk("qualAfterEarly", 1, qEv);
  endtask : t_window

  task automatic t_lock;
    int   n;
    logic seen;
    @(posedge mclk);
    src <= 1'b0;
    tick(3);
    chk("leaveInternal", 0, intl);
    waitEv(P + 300, n);
    chk("firstSync", 1, qEv);
    seen = 1'b0;
    repeat (60) begin
      tick(1);
      seen |= (ppsOut !== 8'h00);
    end
    chk("silentSync", 0, seen);
    waitEv(P + 300, n);
    chk("secondSync", 1, qEv);
    chk("filterComp", 1, near(sub, 16'd25));
    seen = 1'b0;
    repeat (8) begin
      seen |= (ppsOut === 8'hA5);
      tick(1);
    end
    chk("alignedOut", 1, seen);
    chk("locked", 1, locked);
  endtask : t_lock

  task automatic t_loss;
    int   n;
    int   r;
    logic seen;
    ppsSrc.stop();
    waitEv(P + 400, n);
    chk("expired", 1, xEv);
    seen = lost;
    repeat (3) begin
      tick(1);
      seen |= lost;
    end
    chk("lockLost", 1, seen);
    chk("backInternal", 1, intl);
    chk("unlocked", 0, locked);
    r = rises;
    waitEv(P + 100, n);
    chk("expiredAgain", 1, xEv);
    chk("midGap", 1, n + 3 >= P - 1 && n + 3 <= P + 1);
    chk("outKept", 1, rises - r);
  endtask : t_loss

  // Main sequence
  initial begin
    tick(19);
    t_reset();
    @(posedge mclk);
    reset <= 1'b0;
    t_count();
    t_freeze();
    t_trig();
    t_filter();
    t_wrap();
    t_window();
    t_lock();
    t_loss();
    print_verdict();
  end
endmodule : tb
